/* rtl/universal_serial_unit.sv */
`include "serial_unit_defines.svh"
`default_nettype none
module universal_serial_unit (
   // clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   // software register port
   input wire logic [1:0] addr_i,
   input wire serial_unit_pkg::byte_t wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output serial_unit_pkg::byte_t rdata_o,
   // timer compare match, same clock domain
   input wire logic tim0_match_i,
   // interrupt requests
   output logic ovf_irq_o,
   output logic start_irq_o,
   // serial link
   serial_link_if.device link
);
   import serial_unit_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // registers and decode
   byte_t serial_shift_reg;
   byte_t serial_control_reg;
   nibble_t edge_count;
   logic counter_overflow_flag;
   logic start_flag;
   logic do_dir;
   logic ck_dir;
   logic ck_val;
   logic out_latch;
   logic latch_closed;
   logic wr_shift;
   logic wr_status;
   logic wr_control;
   logic wr_port;
   wire_mode_t wire_mode_field;
   logic clock_source_select;
   logic edge_select;
   logic swclk_cfg;

   // address decode for the write strobe
   always_comb begin
      wr_shift = 1'b0;
      wr_status = 1'b0;
      wr_control = 1'b0;
      wr_port = 1'b0;
      if (addr_i == `ADDR_SHIFT) begin
         wr_shift = wr_i;
      end else if (addr_i == `ADDR_STATUS) begin
         wr_status = wr_i;
      end else if (addr_i == `ADDR_CONTROL) begin
         wr_control = wr_i;
      end else begin
         wr_port = wr_i;
      end
   end

   assign wire_mode_field = wire_mode_t'(serial_control_reg[`CR_WM_HI:`CR_WM_LO]);
   assign clock_source_select = serial_control_reg[`CR_CS1];
   assign edge_select = serial_control_reg[`CR_CS0];
   // written value counts in the same cycle it is written
   assign swclk_cfg = wr_control ? wdata_i[`CR_SWCLK] : serial_control_reg[`CR_SWCLK];

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers and edge detection
   logic sck_meta;
   logic sck_sync;
   logic sck_prev;
   logic di_meta;
   logic di_sync;
   logic di_prev;
   logic sck_rise;
   logic sck_fall;

   // two flops on each pin before any logic looks at it
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         sck_meta <= 1'b1;
         sck_sync <= 1'b1;
         sck_prev <= 1'b1;
         di_meta <= 1'b1;
         di_sync <= 1'b1;
         di_prev <= 1'b1;
      end else begin
         sck_meta <= link.sck_line;
         sck_sync <= sck_meta;
         sck_prev <= sck_sync;
         di_meta <= link.prt_to_dev_line; // (R3)
         di_sync <= di_meta;
         di_prev <= di_sync;
      end
   end

   assign sck_rise = sck_sync & ~sck_prev;
   assign sck_fall = ~sck_sync & sck_prev;

   ////////////////////////////////////////////////////////////////////////////
   // clock source selection
   logic samp_edge;
   logic opp_edge;
   logic sw_strobe;
   logic tim_tick;
   logic tc_write;
   logic shift_tick;
   logic cnt_tick;

   // external pin edges chosen by edge select; pin is sampled in every wire mode
   assign samp_edge = clock_source_select & (edge_select ? sck_fall : sck_rise); // (R12) (R22)
   assign opp_edge = clock_source_select & (edge_select ? sck_rise : sck_fall); // (R12)
   assign sw_strobe = wr_control & wdata_i[`CR_SWCLK] & ~clock_source_select & ~edge_select; // (R7) (R20)
   assign tim_tick = ~clock_source_select & edge_select & tim0_match_i; // (R7)
   assign tc_write = wr_control & wdata_i[`CR_TC];
   assign shift_tick = samp_edge | sw_strobe | tim_tick; // (R5) (R7)

   // counter follows the same source, except toggle strobe with software clock on external; external counts both edges
   always_comb begin
      if (clock_source_select && swclk_cfg) begin
         cnt_tick = tc_write; // (R19)
      end else if (clock_source_select) begin
         cnt_tick = sck_rise | sck_fall; // (R6)
      end else begin
         cnt_tick = shift_tick; // (R5)
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // shift register
   // a write wins over a shift landing in the same cycle
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         serial_shift_reg <= `RST_BYTE;
      end else if (wr_shift) begin
         serial_shift_reg <= wdata_i; // (R1) (R21)
      end else if (shift_tick) begin
         serial_shift_reg <= {serial_shift_reg[6:0], di_sync}; // (R1) (R3) (R10)
      end
   end

   // output latch: closed at sampling edge, reopened at opposite edge
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         latch_closed <= 1'b0;
      end else if (samp_edge) begin
         latch_closed <= 1'b1; // (R2)
      end else if (opp_edge || !clock_source_select) begin
         latch_closed <= 1'b0; // (R2)
      end
   end

   // transparent while open, so with an external clock new msb shows only after opposite edge
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         out_latch <= 1'b0;
      end else if (!latch_closed && !samp_edge) begin
         out_latch <= serial_shift_reg[7]; // (R2)
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // edge counter and overflow flag
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         edge_count <= `RST_CNT;
      end else if (wr_status) begin
         edge_count <= wdata_i[`SR_CNT_HI:`SR_CNT_LO]; // (R4) (R18) (R15)
      end else if (cnt_tick) begin
         edge_count <= edge_count + 4'h1; // (R23)
      end
   end

   // a status write wins over the hardware set in the same cycle
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         counter_overflow_flag <= 1'b0;
      end else if (cnt_tick && !wr_status && edge_count == `CNT_MAX) begin
         counter_overflow_flag <= 1'b1; // (R16) (R23)
      end else if (wr_status && wdata_i[`SR_OVF]) begin
         counter_overflow_flag <= 1'b0; // (R18)
      end
   end

   // two-wire start: data falls while clock is high
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         start_flag <= 1'b0;
      end else if (wire_mode_field[1] && sck_sync && di_prev && !di_sync) begin
         start_flag <= 1'b1; // (R8)
      end else if (wr_status && wdata_i[`SR_START]) begin
         start_flag <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control and port registers
   // toggle strobe reads back as zero, so it is never stored
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         serial_control_reg <= `RST_BYTE;
      end else if (wr_control) begin
         serial_control_reg <= {wdata_i[7:1], 1'b0};
      end
   end

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         do_dir <= 1'b0;
         ck_dir <= 1'b0;
         ck_val <= 1'b0;
      end else if (wr_port) begin
         do_dir <= wdata_i[`PR_DO_DIR]; // (R14)
         ck_dir <= wdata_i[`PR_CK_DIR];
         ck_val <= wdata_i[`PR_CK_VAL]; // (R11)
      end else if (tc_write) begin
         ck_val <= ~ck_val; // (R19) (R11)
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin drivers; two-wire pins are open drain and may hold clock low
   logic hold_low;
   assign hold_low = start_flag | ((wire_mode_field == WM_TWO_HOLD) & counter_overflow_flag); // (R8)

   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         link.dev_sck_o <= 1'b0;
         link.dev_sck_oe_n <= 1'b1;
         link.dev_do_o <= 1'b0;
         link.dev_do_oe_n <= 1'b1;
      end else begin
         case (wire_mode_field)
            WM_NONE: begin
               link.dev_sck_o <= 1'b0; // (R22)
               link.dev_sck_oe_n <= 1'b1;
               link.dev_do_o <= 1'b0;
               link.dev_do_oe_n <= 1'b1;
            end
            WM_THREE: begin
               link.dev_sck_o <= ck_val; // (R9)
               link.dev_sck_oe_n <= ~ck_dir;
               link.dev_do_o <= out_latch; // (R2)
               link.dev_do_oe_n <= ~do_dir; // (R14)
            end
            default: begin
               link.dev_sck_o <= 1'b0;
               link.dev_sck_oe_n <= ~(hold_low | (ck_dir & ~ck_val)); // (R8)
               link.dev_do_o <= 1'b0;
               link.dev_do_oe_n <= ~(do_dir & ~out_latch);
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read data and interrupt requests
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         rdata_o <= `RST_BYTE;
      end else if (rd_i) begin
         if (addr_i == `ADDR_SHIFT) begin
            rdata_o <= serial_shift_reg; // (R1)
         end else if (addr_i == `ADDR_STATUS) begin
            rdata_o <= {counter_overflow_flag, start_flag, 2'b00, edge_count}; // (R4)
         end else if (addr_i == `ADDR_CONTROL) begin
            rdata_o <= serial_control_reg;
         end else begin
            rdata_o <= {5'h00, ck_val, ck_dir, do_dir};
         end
      end
   end

   // level requests; overflow request also serves as idle wake-up
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         ovf_irq_o <= 1'b0;
         start_irq_o <= 1'b0;
      end else begin
         ovf_irq_o <= counter_overflow_flag & serial_control_reg[`CR_OVF_IE]; // (R4) (R17)
         start_irq_o <= start_flag & serial_control_reg[`CR_START_IE]; // (R8)
      end
   end
endmodule : universal_serial_unit
`default_nettype wire

/* rtl/serial_unit_defines.svh */
// Overview of operation
// (R1) 8-bit unbuffered shift register, MSB drives output
// (R2) output latch changes on opposite clock edge
// (R3) serial input always taken from data-in
// (R4) readable, writable 4-bit counter with overflow interrupt
// (R5) shift register and counter share one clock
// (R6) external clock: counter counts both edges
// (R7) clock from pin, timer match or software
// (R8) two-wire: start interrupt, hold clock low
// (R9) three-wire works as spi modes 0, 1
// (R10) two units exchange bytes after eight clocks
// (R11) master clocks by port toggle or strobe
// (R12) edge select picks sampling and shifting edges
// (R13) load and enable output half cycle early
// (R14) output enabled by direction bit; slave releases
// (R15) software clears counter before each byte
// (R16) sixteen edges overflow counter, set flag
// (R17) enabled overflow interrupt wakes idle processor
// (R18) status write loads counter, clears flag by one
// (R19) toggle strobe counts and toggles clock pin
// (R20) alternate control writes give half system clock
// (R21) write beats simultaneous shift
// (R22) wire mode zero still feeds shift register
// (R23) overflow on wrap fifteen to zero, keeps counting
`ifndef SERIAL_UNIT_DEFINES_SVH
`define SERIAL_UNIT_DEFINES_SVH
// register addresses
`define ADDR_SHIFT 2'h0
`define ADDR_STATUS 2'h1
`define ADDR_CONTROL 2'h2
`define ADDR_PORT 2'h3
// control register bits
`define CR_START_IE 7
`define CR_OVF_IE 6
`define CR_WM_HI 5
`define CR_WM_LO 4
`define CR_CS1 3
`define CR_CS0 2
`define CR_SWCLK 1
`define CR_TC 0
// status register bits
`define SR_OVF 7
`define SR_START 6
`define SR_CNT_HI 3
`define SR_CNT_LO 0
// port register bits
`define PR_DO_DIR 0
`define PR_CK_DIR 1
`define PR_CK_VAL 2
// reset values and count limits
`define RST_BYTE 8'h00
`define RST_CNT 4'h0
`define CNT_MAX 4'hF
`define EDGE_LAST 5'h0F
// timing
`define MCLK_PERIOD_NS 5
`define SCK_HALF_NS 80
`define SCK_HALF_CYC ((`SCK_HALF_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)
`endif

/* rtl/serial_unit_pkg.sv */
`default_nettype none
package serial_unit_pkg;
   typedef logic [7:0] byte_t;
   typedef logic [3:0] nibble_t;
   typedef enum logic [1:0] {WM_NONE, WM_THREE, WM_TWO, WM_TWO_HOLD} wire_mode_t;
   typedef enum logic {PS_IDLE, PS_RUN} partner_state_t;
endpackage : serial_unit_pkg
`default_nettype wire

/* rtl/serial_link_if.sv */
`default_nettype none
interface serial_link_if;
   // device end drive
   logic dev_sck_o;
   logic dev_sck_oe_n;
   logic dev_do_o;
   logic dev_do_oe_n;
   // partner end drive
   logic prt_sck_o;
   logic prt_sck_oe_n;
   logic prt_do_o;
   logic prt_do_oe_n;
   // resolved wires, pulled high when undriven
   logic sck_line;
   logic dev_to_prt_line;
   logic prt_to_dev_line;
   assign sck_line = !dev_sck_oe_n ? dev_sck_o : (!prt_sck_oe_n ? prt_sck_o : 1'b1);
   assign dev_to_prt_line = !dev_do_oe_n ? dev_do_o : 1'b1;
   assign prt_to_dev_line = !prt_do_oe_n ? prt_do_o : 1'b1;
   modport device (output dev_sck_o, dev_sck_oe_n, dev_do_o, dev_do_oe_n,
                   input sck_line, prt_to_dev_line);
   modport partner (output prt_sck_o, prt_sck_oe_n, prt_do_o, prt_do_oe_n,
                    input sck_line, dev_to_prt_line);
endinterface : serial_link_if
`default_nettype wire

/* rtl/serial_partner.sv */
`include "serial_unit_defines.svh"
`default_nettype none
module serial_partner (
   // clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   // user side
   input wire logic start_i,
   input wire serial_unit_pkg::byte_t tx_byte_i,
   input wire logic master_i,
   input wire logic edge_select_i,
   output serial_unit_pkg::byte_t rx_byte_o,
   output logic done_o,
   output logic busy_o,
   // serial link
   serial_link_if.partner link
);
   import serial_unit_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // state
   localparam int HALF_CYC = `SCK_HALF_CYC;
   partner_state_t state;
   byte_t sh;
   byte_t next_sh;
   logic [4:0] edges;
   logic [5:0] half_cnt;
   logic sck_q;
   logic sck_meta;
   logic sck_sync;
   logic sck_prev;
   logic di_meta;
   logic di_sync;
   logic gen_edge;
   logic rise;
   logic fall;
   logic samp;
   logic opp;

   // pin synchronisers
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         sck_meta <= 1'b0;
         sck_sync <= 1'b0;
         sck_prev <= 1'b0;
         di_meta <= 1'b1;
         di_sync <= 1'b1;
      end else begin
         sck_meta <= link.sck_line;
         sck_sync <= sck_meta;
         sck_prev <= sck_sync;
         di_meta <= link.dev_to_prt_line;
         di_sync <= di_meta;
      end
   end

   // master uses its own divider edges, slave the sampled pin
   assign gen_edge = (state == PS_RUN) & master_i & (half_cnt == 6'(HALF_CYC - 1));
   assign rise = master_i ? (gen_edge & ~sck_q) : (sck_sync & ~sck_prev);
   assign fall = master_i ? (gen_edge & sck_q) : (~sck_sync & sck_prev);
   assign samp = (state == PS_RUN) & (edge_select_i ? fall : rise); // (R12)
   assign opp = (state == PS_RUN) & (edge_select_i ? rise : fall);
   assign next_sh = samp ? {sh[6:0], di_sync} : sh;

   ////////////////////////////////////////////////////////////////////////////
   // clock divider; first edge comes a full half period after load
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         half_cnt <= 6'h00;
         sck_q <= 1'b0;
      end else if (state == PS_IDLE) begin
         half_cnt <= 6'h00; // (R13)
      end else if (gen_edge) begin
         half_cnt <= 6'h00;
         sck_q <= ~sck_q; // (R11)
      end else begin
         half_cnt <= half_cnt + 6'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // transfer sequencing: sixteen edges make one byte
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         state <= PS_IDLE;
         sh <= `RST_BYTE;
         edges <= 5'h00;
         rx_byte_o <= `RST_BYTE;
         done_o <= 1'b0;
         busy_o <= 1'b0;
         link.prt_do_o <= 1'b1;
         link.prt_do_oe_n <= 1'b1;
      end else begin
         done_o <= 1'b0;
         case (state)
            PS_IDLE: begin
               if (start_i) begin
                  state <= PS_RUN;
                  sh <= tx_byte_i;
                  edges <= 5'h00; // (R15)
                  busy_o <= 1'b1;
                  link.prt_do_o <= tx_byte_i[7]; // (R13)
                  link.prt_do_oe_n <= 1'b0; // (R13) (R14)
               end
            end
            default: begin
               sh <= next_sh; // (R10)
               if (opp) begin
                  link.prt_do_o <= sh[7];
               end
               if (rise || fall) begin
                  edges <= edges + 5'h01;
                  if (edges == `EDGE_LAST) begin
                     state <= PS_IDLE; // (R10)
                     rx_byte_o <= next_sh;
                     done_o <= 1'b1;
                     busy_o <= 1'b0;
                     link.prt_do_oe_n <= 1'b1; // (R14)
                  end
               end
            end
         endcase
      end
   end

   // master drives the clock line, slave leaves it alone
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i) begin
         link.prt_sck_o <= 1'b0;
         link.prt_sck_oe_n <= 1'b1;
      end else begin
         link.prt_sck_o <= sck_q;
         link.prt_sck_oe_n <= ~master_i;
      end
   end
endmodule : serial_partner
`default_nettype wire

/* testbench/serial_link_chk.sv */
`default_nettype none
module serial_link_chk (
   // clock and reset
   input wire logic mclk_i,
   input wire logic sys_rst_i,
   // link signals of both ends
   input wire logic dev_sck_o,
   input wire logic dev_sck_oe_n,
   input wire logic dev_do_o,
   input wire logic dev_do_oe_n,
   input wire logic prt_sck_o,
   input wire logic prt_sck_oe_n,
   input wire logic prt_do_o,
   input wire logic prt_do_oe_n,
   input wire logic sck_line
);
   timeunit 1ns;
   timeprecision 1ps;
   logic sck_q;
   logic drv_q;
   logic oe_q;
   logic drv;
   logic [4:0] rise_cnt;
   logic [4:0] fall_cnt;

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (sys_rst_i);

   ////////////////////////////////////////////////////////////////////////////
   // the clock line counts as driven only while some end enables its driver
   assign drv = !dev_sck_oe_n || !prt_sck_oe_n;

   // history of the link for edge detection
   always_ff @(posedge mclk_i) begin
      sck_q <= sck_line;
      drv_q <= drv;
      oe_q <= prt_do_oe_n;
   end

   // edges per partner transfer; taking or releasing the line is no edge
   always_ff @(posedge mclk_i) begin
      if (sys_rst_i || (oe_q && !prt_do_oe_n)) begin
         rise_cnt <= 5'h00;
         fall_cnt <= 5'h00;
      end else if (drv && drv_q && sck_line != sck_q) begin
         rise_cnt <= rise_cnt + {4'h0, sck_line};
         fall_cnt <= fall_cnt + {4'h0, !sck_line};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // explicit disable so that the reset cycle itself is checked
   reset_release_a: assert property (disable iff (1'h0) sys_rst_i |=> dev_sck_oe_n && dev_do_oe_n && prt_sck_oe_n && prt_do_oe_n)
      else $error("a link driver is enabled after reset");
   sck_single_driver_a: assert property (!(!dev_sck_oe_n && !prt_sck_oe_n))
      else $error("both ends drive the serial clock");
   dev_out_hold_a: assert property (!dev_do_oe_n && $changed(sck_line) |=> $stable(dev_do_o) [*2])
      else $error("device data out changes right at a clock edge");
   dev_out_setup_a: assert property ($rose(sck_line) && !dev_do_oe_n && $past(dev_do_oe_n, 3) == 1'h0
                                     |-> dev_do_o == $past(dev_do_o, 3))
      else $error("device data out not set up before sampling edge");
   rise_count_a: assert property ($rose(prt_do_oe_n) |-> ##2 rise_cnt == 5'h08)
      else $error("serial clock pulses per byte are not eight");
   edge_count_a: assert property ($rose(prt_do_oe_n) |-> ##2 (fall_cnt + rise_cnt) == 5'h10)
      else $error("serial clock edges per byte are not sixteen");
   half_period_a: assert property (!prt_sck_oe_n && $changed(prt_sck_o) |=> $stable(prt_sck_o) [*8])
      else $error("partner clock phase shorter than eight cycles");
   // the last edge reaches the pin one cycle after the data driver lets go
   clock_with_data_a: assert property (prt_do_oe_n && $past(prt_do_oe_n, 2) && !prt_sck_oe_n |-> $stable(prt_sck_o))
      else $error("partner clocks with its data driver released");

   // main scenarios
   cover property ($rose(prt_do_oe_n) && !dev_sck_oe_n);
   cover property ($rose(prt_do_oe_n) && !prt_sck_oe_n);
   cover property (!dev_do_oe_n && $rose(sck_line));
endmodule : serial_link_chk
`default_nettype wire

/* testbench/universal_serial_three_wire_shifter_tb.sv */
`include "serial_unit_defines.svh"
`default_nettype none
module universal_serial_three_wire_shifter_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import serial_unit_pkg::*;
   logic mclk_i, sys_rst_i, wr_i, rd_i, tim0_match_i, ovf_irq_o, start_irq_o;
   logic start_i, master_i, edge_select_i, done_o, busy_o;
   logic [1:0] addr_i;
   byte_t wdata_i, rdata_o, tx_byte_i, rx_byte_o, got;
   int failures, tests_run;

   ////////////////////////////////////////////////////////////////////////////
   // both ends meet on one link, the checker watches it
   serial_link_if serial_link_if_inst ();
   universal_serial_unit universal_serial_unit_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .tim0_match_i(tim0_match_i),
      .ovf_irq_o(ovf_irq_o), .start_irq_o(start_irq_o), .link(serial_link_if_inst));
   serial_partner serial_partner_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .start_i(start_i),
      .tx_byte_i(tx_byte_i), .master_i(master_i), .edge_select_i(edge_select_i), .rx_byte_o(rx_byte_o),
      .done_o(done_o), .busy_o(busy_o), .link(serial_link_if_inst));
   serial_link_chk serial_link_chk_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i),
      .dev_sck_o(serial_link_if_inst.dev_sck_o), .dev_sck_oe_n(serial_link_if_inst.dev_sck_oe_n),
      .dev_do_o(serial_link_if_inst.dev_do_o), .dev_do_oe_n(serial_link_if_inst.dev_do_oe_n),
      .prt_sck_o(serial_link_if_inst.prt_sck_o), .prt_sck_oe_n(serial_link_if_inst.prt_sck_oe_n),
      .prt_do_o(serial_link_if_inst.prt_do_o), .prt_do_oe_n(serial_link_if_inst.prt_do_oe_n),
      .sck_line(serial_link_if_inst.sck_line));

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask : check

   task automatic wr(input logic [1:0] a, input byte_t d);
      @(posedge mclk_i);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'h1;
      @(posedge mclk_i);
      wr_i <= 1'h0;
   endtask : wr

   // read data appear in the cycle after the strobe and hold until the next read
   task automatic rd(input logic [1:0] a, input byte_t exp, input string what);
      @(posedge mclk_i);
      addr_i <= a;
      rd_i <= 1'h1;
      @(posedge mclk_i);
      rd_i <= 1'h0;
      @(negedge mclk_i);
      check(what, rdata_o, exp);
   endtask : rd

   task automatic partner_go(input logic m, input logic e, input byte_t b);
      @(posedge mclk_i);
      master_i <= m;
      edge_select_i <= e;
      tx_byte_i <= b;
      start_i <= 1'h1;
      @(posedge mclk_i);
      start_i <= 1'h0;
   endtask : partner_go

   // bounded wait; a missing pulse shows up as a stale byte
   task automatic wait_done;
      for (int i = 0; i < 4000; i++) begin
         @(negedge mclk_i);
         if (done_o === 1'h1) break;
      end
      got = rx_byte_o;
   endtask : wait_done

   task automatic stop_test;
      $display("comparisons %0d, mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : stop_test

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      mclk_i = 1'h0;
      forever #2.5 mclk_i = ~mclk_i;
   end

   // watchdog, far beyond the thousand or so cycles the sequence needs
   initial begin
      repeat (20000) @(posedge mclk_i);
      failures++;
      stop_test();
   end

   initial begin
      {sys_rst_i, wr_i, rd_i, tim0_match_i, start_i, master_i, edge_select_i} = 7'h40;
      {addr_i, wdata_i, tx_byte_i} = 18'h00000;
      repeat (20) @(posedge mclk_i);
      sys_rst_i <= 1'h0;
      for (int a = 0; a < 4; a++) rd(a[1:0], 8'h00, "reset value");
      // software strobe counts 14, 15, wraps; undriven data input reads as ones
      wr(`ADDR_STATUS, 8'h0E);
      wr(`ADDR_CONTROL, 8'h02);
      wr(`ADDR_CONTROL, 8'h02);
      rd(`ADDR_STATUS, 8'h80, "status after wrap");
      rd(`ADDR_SHIFT, 8'h03, "shift from data input");
      wr(`ADDR_STATUS, 8'h85);
      rd(`ADDR_STATUS, 8'h05, "status after load");
      wr(`ADDR_CONTROL, 8'h01);
      rd(`ADDR_PORT, 8'h04, "clock pin toggled");
      rd(`ADDR_CONTROL, 8'h00, "toggle strobe reads zero");
      // timer match as clock source, then a write racing a tick
      wr(`ADDR_CONTROL, 8'h04);
      wr(`ADDR_STATUS, 8'h00);
      @(posedge mclk_i);
      tim0_match_i <= 1'h1;
      @(posedge mclk_i);
      tim0_match_i <= 1'h0;
      rd(`ADDR_STATUS, 8'h01, "count after timer match");
      rd(`ADDR_SHIFT, 8'h07, "shift after timer match");
      @(posedge mclk_i);
      tim0_match_i <= 1'h1;
      addr_i <= `ADDR_SHIFT;
      wdata_i <= 8'h5A;
      wr_i <= 1'h1;
      @(posedge mclk_i);
      tim0_match_i <= 1'h0;
      wr_i <= 1'h0;
      rd(`ADDR_SHIFT, 8'h5A, "written shift beats tick");
      // device master by toggle strobe writes, partner slave
      wr(`ADDR_PORT, 8'h03);
      wr(`ADDR_CONTROL, 8'h18);
      // taking the clock line low is a counted edge; let it pass before clearing
      repeat (8) @(posedge mclk_i);
      wr(`ADDR_STATUS, 8'h80);
      wr(`ADDR_SHIFT, 8'h96);
      partner_go(1'h0, 1'h0, 8'hC3);
      repeat (16) begin
         repeat (12) @(posedge mclk_i);
         wr(`ADDR_CONTROL, 8'h1B);
      end
      wait_done();
      check("partner byte from master", got, 8'h96);
      repeat (8) @(posedge mclk_i);
      rd(`ADDR_SHIFT, 8'hC3, "master received byte");
      rd(`ADDR_STATUS, 8'h80, "overflow after strobes");
      check("masked overflow request", {7'h00, ovf_irq_o}, 8'h00);
      // device slave in both edge modes; partner takes the clock first
      wr(`ADDR_PORT, 8'h01);
      for (int e = 0; e < 2; e++) begin
         wr(`ADDR_CONTROL, {5'h0B, e[0], 2'h0});
         partner_go(1'h1, e[0], 8'h3C ^ e[7:0]);
         repeat (6) @(posedge mclk_i);
         wr(`ADDR_SHIFT, 8'hA5);
         wr(`ADDR_STATUS, 8'h80);
         wait_done();
         check("partner byte from slave", got, 8'hA5);
         repeat (8) @(posedge mclk_i);
         rd(`ADDR_SHIFT, 8'h3C ^ e[7:0], "slave received byte");
         rd(`ADDR_STATUS, 8'h80, "slave overflow");
         check("overflow request", {7'h00, ovf_irq_o}, 8'h01);
      end
      wr(`ADDR_STATUS, 8'h80);
      repeat (3) @(negedge mclk_i);
      check("cleared request", {7'h00, ovf_irq_o}, 8'h00);
      stop_test();
   end
endmodule : universal_serial_three_wire_shifter_tb
`default_nettype wire
